// [logic/sac_pkg.sv]
// Package of constants and types for the converter control block
// Functional notes
// - Input above upper reference saturates result to all ones, no overflow flag.
// - Input below lower reference gives a zero result in both bytes.
// - Control bits 3:0 select analog input 0 to 15.
// - Converter-on bit enables converter; conversions repeat continuously until cleared.
// - Each completion sets end-of-conversion flag and loads the result unless locked.
// - Flag clears on high byte read or any control register write.
// - Channel change aborts conversion, clears flag, restarts on new channel.
// - Low byte read locks both result bytes.
// - High byte read or converter-on cleared unlocks the result.
// - Locked result is not updated by completions.
// - Clearing converter-on stops any conversion and powers the converter down.
// - Speed and slow bits pick converter clock: /2, /1, /4, /2.
// - Wait mode no effect; halt disables; stabilization delay after halt wakeup.
// - High byte holds bits 9:2, low byte bits 1:0.
// - Low byte bits 7:2 read zero.
// - Control register resets to zero; bit 7 is read only.
// - Analog use leaves the pin's logic level readable.
package sac_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CSR = 8'h45;
    localparam logic [7:0] IDX_RES_HI = 8'h46;
    localparam logic [7:0] IDX_RES_LO = 8'h47;
    // Control register fields
    localparam int CSR_EOC = 7;
    localparam int CSR_SPEED = 6;
    localparam int CSR_CONVERTER_ON = 5;
    localparam int CSR_SLOW = 4;
    localparam int CH_MSB = 3;
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [7:0] CSR_WR_MASK = 8'h7F;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [5:0] LO_PAD = 6'h00;
    localparam logic [9:0] RES_RST = 10'h000;
    localparam logic [9:0] TRIAL_MSB = 10'h200;
    localparam logic [3:0] TOP_BIT = 4'h9;
    localparam logic [3:0] SAMPLE_TICKS = 4'h3;
    // Converter clock divider terminal counts
    localparam logic [1:0] DIV1_LAST = 2'h0;
    localparam logic [1:0] DIV2_LAST = 2'h1;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    // Clock period
    localparam int CLK_NS = 10;
    typedef enum {SEQ_IDLE, SEQ_SAMPLE, SEQ_STEP} sac_seq_t;
endpackage

// [logic/sac_sar_if.sv]
// Interface between the control logic and the approximation sequencer
`timescale 1ns/1ps
interface sac_sar_if;
    logic tick;
    logic start;
    logic abort;
    logic cmp_hi;
    logic sample;
    logic busy;
    logic done;
    logic [9:0] trial;
    logic [9:0] result;
    modport ctrl (output tick, start, abort, cmp_hi, input sample, busy, done, trial, result);
    modport seq (input tick, start, abort, cmp_hi, output sample, busy, done, trial, result);
endinterface

// [logic/sac_sar_seq.sv]
// Successive approximation sequencer: sampling then ten binary steps
`timescale 1ns/1ps
module sac_sar_seq (
    input wire logic clk, // System clock
    input wire logic arst_n, // Async reset, active low
    sac_sar_if.seq sar // Control side
);
    sac_pkg::sac_seq_t state_ff;
    logic [3:0] cnt_ff;
    logic [3:0] bit_ff;
    logic [9:0] trial_ff;
    logic [9:0] result_ff;
    logic done_ff;
    logic [9:0] nxt_trial;

    // Drop the trial bit when the input is below the trial level
    always_comb begin
        nxt_trial = trial_ff;
        if (!sar.cmp_hi) begin
            nxt_trial[bit_ff] = 1'b0;
        end
    end

    // Sequence: all-high compares end at all ones, all-low at zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= sac_pkg::SEQ_IDLE;
            cnt_ff <= 4'h0;
            bit_ff <= 4'h0;
            trial_ff <= sac_pkg::RES_RST;
            result_ff <= sac_pkg::RES_RST;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (sar.abort) begin
                state_ff <= sac_pkg::SEQ_IDLE;
            end else begin
                unique case (state_ff)
                    sac_pkg::SEQ_IDLE: begin
                        if (sar.start) begin
                            state_ff <= sac_pkg::SEQ_SAMPLE;
                            cnt_ff <= 4'h0;
                            trial_ff <= sac_pkg::TRIAL_MSB;
                        end
                    end
                    sac_pkg::SEQ_SAMPLE: begin
                        if (sar.tick) begin
                            if (cnt_ff == 4'(sac_pkg::SAMPLE_TICKS - 4'h1)) begin
                                state_ff <= sac_pkg::SEQ_STEP;
                                bit_ff <= sac_pkg::TOP_BIT;
                            end else begin
                                cnt_ff <= 4'(cnt_ff + 4'h1);
                            end
                        end
                    end
                    sac_pkg::SEQ_STEP: begin
                        if (sar.tick) begin
                            if (bit_ff == 4'h0) begin
                                result_ff <= nxt_trial;
                                done_ff <= 1'b1;
                                state_ff <= sac_pkg::SEQ_IDLE;
                            end else begin
                                trial_ff <= nxt_trial;
                                trial_ff[4'(bit_ff - 4'h1)] <= 1'b1;
                                bit_ff <= 4'(bit_ff - 4'h1);
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign sar.sample = (state_ff == sac_pkg::SEQ_SAMPLE);
    assign sar.busy = (state_ff != sac_pkg::SEQ_IDLE);
    assign sar.done = done_ff;
    assign sar.trial = trial_ff;
    assign sar.result = result_ff;
endmodule

// [logic/sac_adc_ctrl.sv]
// Converter control top: Wishbone registers, clocking, lock, flag and power
`timescale 1ns/1ps
module sac_adc_ctrl #(
    parameter int STAB_NS = 10000 // Stabilization time after halt wakeup
) (
    input wire logic CLK, // System clock, 100 MHz
    input wire logic ARST_N, // Async reset, active low
    input wire logic WB_CYC_I, // Bus cycle
    input wire logic WB_STB_I, // Strobe
    input wire logic WB_WE_I, // Write enable
    input wire logic [9:0] WB_ADR_I, // Byte address
    input wire logic [3:0] WB_SEL_I, // Byte lanes
    input wire logic [31:0] WB_DAT_I, // Write data
    output logic [31:0] WB_DAT_O, // Read data
    output logic WB_ACK_O, // Acknowledge
    input wire logic HALT_MODE, // Halt low-power mode
    input wire logic WAIT_MODE, // Wait low-power mode
    input wire logic CMP_HI, // Input above trial level
    input wire logic [15:0] PIN_LEVEL_I, // Logic level of input pins
    output logic [15:0] PIN_LEVEL_O, // Pin levels for port reads
    output logic [3:0] CHAN_SEL, // Analog mux select
    output logic CONV_EN, // Converter power enable
    output logic SAMPLE, // Sample and hold active
    output logic [9:0] TRIAL_CODE // Trial code to comparator DAC
);
    localparam int STAB_CYC = (STAB_NS + sac_pkg::CLK_NS - 1) / sac_pkg::CLK_NS;
    localparam logic [19:0] STAB_LOAD = 20'(STAB_CYC);

    sac_sar_if sar ();

    logic ack_ff;
    logic [31:0] dat_ff;
    logic [6:0] csr_ff;
    logic eoc_ff;
    logic lock_ff;
    logic [9:0] res_ff;
    logic [1:0] div_ff;
    logic tick;
    logic [1:0] div_last;
    logic [19:0] stab_ff;
    logic [15:0] pin_ff;
    logic acc;
    logic wr_csr;
    logic rd_hi;
    logic rd_lo;
    logic ch_change;
    logic converter_on_off;
    logic run;
    logic [7:0] idx;
    logic [7:0] rd_byte;

    // Access decode; one access per transfer, on its first cycle
    assign idx = WB_ADR_I[9:2];
    assign acc = WB_CYC_I && WB_STB_I && !ack_ff;
    assign wr_csr = acc && WB_WE_I && WB_SEL_I[0] && (idx == sac_pkg::IDX_CSR);
    assign rd_hi = acc && !WB_WE_I && (idx == sac_pkg::IDX_RES_HI);
    assign rd_lo = acc && !WB_WE_I && (idx == sac_pkg::IDX_RES_LO);
    assign ch_change = wr_csr && (WB_DAT_I[sac_pkg::CH_MSB:0] != csr_ff[sac_pkg::CH_MSB:0]);
    assign converter_on_off = wr_csr && !WB_DAT_I[sac_pkg::CSR_CONVERTER_ON];

    // Halt gates the converter; wait mode deliberately has no effect here
    assign run = csr_ff[sac_pkg::CSR_CONVERTER_ON] && !HALT_MODE && (stab_ff == 20'h0);

    // Read mux; unmapped addresses read zero
    always_comb begin
        unique case (idx)
            sac_pkg::IDX_CSR: rd_byte = {eoc_ff, csr_ff};
            sac_pkg::IDX_RES_HI: rd_byte = res_ff[9:2];
            sac_pkg::IDX_RES_LO: rd_byte = {sac_pkg::LO_PAD, res_ff[1:0]};
            default: rd_byte = sac_pkg::BYTE_ZERO;
        endcase
    end

    // Bus answer: ack one cycle after the request, dropped the next cycle
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end else begin
            ack_ff <= acc;
            if (acc && !WB_WE_I) begin
                dat_ff <= {24'h000000, rd_byte};
            end
        end
    end
    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = dat_ff;

    // Control bits; bit 7 is not writable
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            csr_ff <= sac_pkg::CSR_RST[6:0];
        end else if (wr_csr) begin
            csr_ff <= WB_DAT_I[6:0] & sac_pkg::CSR_WR_MASK[6:0];
        end
    end

    // End-of-conversion flag: a completion wins over a clearing access,
    // except a channel change, whose abort makes the old result stale
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            eoc_ff <= 1'b0;
        end else if (sar.done && !ch_change && run) begin
            eoc_ff <= 1'b1;
        end else if (rd_hi || wr_csr) begin
            eoc_ff <= 1'b0;
        end
    end

    // Result lock keeps the two bytes from one sample unless a completion comes in the low byte read's cycle
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lock_ff <= 1'b0;
        end else if (rd_hi || converter_on_off) begin
            lock_ff <= 1'b0;
        end else if (rd_lo) begin
            lock_ff <= 1'b1;
        end
    end

    // Result update; completions are dropped while locked
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            res_ff <= sac_pkg::RES_RST;
        end else if (sar.done && run && !ch_change && !lock_ff) begin
            res_ff <= sar.result;
        end
    end

    // Converter clock tick from the speed and slow bits
    always_comb begin
        unique case ({csr_ff[sac_pkg::CSR_SLOW], csr_ff[sac_pkg::CSR_SPEED]})
            2'b01: div_last = sac_pkg::DIV1_LAST;
            2'b10: div_last = sac_pkg::DIV4_LAST;
            default: div_last = sac_pkg::DIV2_LAST;
        endcase
    end
    assign tick = (div_ff >= div_last);

    // Divider; restarts on wrap so a faster setting takes effect at once
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_ff <= 2'h0;
        end else if (tick) begin
            div_ff <= 2'h0;
        end else begin
            div_ff <= 2'(div_ff + 2'h1);
        end
    end

    // Stabilization count reloads during halt, counts down after wakeup
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stab_ff <= 20'h0;
        end else if (HALT_MODE) begin
            stab_ff <= STAB_LOAD;
        end else if (stab_ff != 20'h0) begin
            stab_ff <= 20'(stab_ff - 20'h1);
        end
    end

    // Pin levels stay readable whatever the converter does
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_ff <= 16'h0000;
        end else begin
            pin_ff <= PIN_LEVEL_I;
        end
    end
    assign PIN_LEVEL_O = pin_ff;

    // Sequencer control: continuous restart, abort on off or channel change
    assign sar.tick = tick;
    assign sar.start = run && !sar.busy;
    assign sar.abort = !run || ch_change;
    assign sar.cmp_hi = CMP_HI;

    sac_sar_seq u_seq (
        .clk(CLK),
        .arst_n(ARST_N),
        .sar(sar.seq)
    );

    // Analog side; power follows the on bit and halt
    assign CHAN_SEL = csr_ff[sac_pkg::CH_MSB:0];
    assign CONV_EN = csr_ff[sac_pkg::CSR_CONVERTER_ON] && !HALT_MODE;
    assign SAMPLE = sar.sample;
    assign TRIAL_CODE = sar.trial;

    // Checks on flag, lock, abort and clocking
    AST_EOC_SET: assert property (@(posedge CLK) disable iff (!ARST_N)
        sar.done && run && !ch_change |=> eoc_ff)
        else $error("flag not set on completion");
    AST_EOC_CLR_RD: assert property (@(posedge CLK) disable iff (!ARST_N)
        rd_hi && !sar.done |=> !eoc_ff && WB_DAT_O[7:0] == $past(res_ff[9:2]))
        else $error("flag not cleared by high byte read");
    AST_EOC_CLR_WR: assert property (@(posedge CLK) disable iff (!ARST_N)
        wr_csr && !sar.done |=> !eoc_ff)
        else $error("flag not cleared by control write");
    AST_CH_ABORT: assert property (@(posedge CLK) disable iff (!ARST_N)
        ch_change |=> !sar.busy && !eoc_ff)
        else $error("channel change did not abort");
    AST_LOCK_SET: assert property (@(posedge CLK) disable iff (!ARST_N)
        rd_lo && !converter_on_off |=> lock_ff)
        else $error("low byte read did not lock");
    AST_UNLOCK: assert property (@(posedge CLK) disable iff (!ARST_N)
        rd_hi || converter_on_off |=> !lock_ff)
        else $error("result not unlocked");
    AST_LOCK_HOLD: assert property (@(posedge CLK) disable iff (!ARST_N)
        lock_ff && !rd_hi |=> $stable(res_ff))
        else $error("locked result changed");
    AST_OFF_STOP: assert property (@(posedge CLK) disable iff (!ARST_N)
        !csr_ff[sac_pkg::CSR_CONVERTER_ON] && !wr_csr |=> !sar.busy && !CONV_EN)
        else $error("converter ran while off");
    AST_LO_ZERO: assert property (@(posedge CLK) disable iff (!ARST_N)
        rd_lo |=> WB_DAT_O[7:2] == 6'h00)
        else $error("low byte upper bits not zero");
    AST_DIV4: assert property (@(posedge CLK) disable iff (!ARST_N)
        csr_ff[sac_pkg::CSR_SLOW] && !csr_ff[sac_pkg::CSR_SPEED] && tick
        |=> (!tick || csr_ff[sac_pkg::CSR_SPEED] || !csr_ff[sac_pkg::CSR_SLOW]) [*3])
        else $error("slow clock not divided by four");
    AST_CH_OUT: assert property (@(posedge CLK) disable iff (!ARST_N)
        wr_csr |=> CHAN_SEL == $past(WB_DAT_I[3:0]))
        else $error("channel select not applied");

    COV_DONE: cover property (@(posedge CLK) disable iff (!ARST_N) sar.done && run);
    COV_LOCKED_DROP: cover property (@(posedge CLK) disable iff (!ARST_N)
        sar.done && lock_ff);
    COV_CH_ABORT: cover property (@(posedge CLK) disable iff (!ARST_N)
        ch_change && sar.busy);
    COV_HALT_WAKE: cover property (@(posedge CLK) disable iff (!ARST_N)
        $fell(HALT_MODE) && csr_ff[sac_pkg::CSR_CONVERTER_ON]);
endmodule

// [tb/sac_analog_model.sv]
// Behavioural analog front end: per-channel input levels and comparator
`timescale 1ns/1ps
module sac_analog_model (
    input wire logic clk, // System clock
    input wire logic [3:0] chan_sel, // Mux select
    input wire logic conv_en, // Converter power
    input wire logic [9:0] trial_code, // Trial code from sequencer
    output logic cmp_hi // Comparator result
);
    int level [16] = '{default: 0}; // Codes; above 1023 or below 0 saturate
    logic junk = 1'b0;
    // Unpowered comparator says nothing useful, so it toggles
    always @(posedge clk) begin
        junk <= ~junk;
    end
    // Mux routes channel n; input at or above trial keeps the bit
    always_comb begin
        if (!conv_en) begin
            cmp_hi = junk;
        end else begin
            cmp_hi = (level[chan_sel] >= int'(trial_code));
        end
    end
endmodule

// [tb/sar_adc_control_logic_tb.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sar_adc_control_logic_tb;
    typedef struct {logic chk; logic [7:0] val;} sac_note_t;
    sac_note_t notes[$];
    sac_note_t cur;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic halt = 1'b0;
    logic wt = 1'b0;
    logic [3:0] sel = 4'hF;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [15:0] pin_i = 16'h0000;
    logic [15:0] pin_q = 16'h0000;
    logic [15:0] lfsr = 16'hACFF; // Seed 44287
    logic [31:0] rdat;
    logic [15:0] pin_o;
    logic [3:0] chan;
    logic [9:0] trial;
    logic [9:0] trial_q = 10'h000;
    logic ack, cmp, conv_en, sample;
    logic armed = 1'b0;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int gcnt = 0;
    int gap = 0;
    sac_adc_ctrl #(.STAB_NS(50)) uut (.CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .HALT_MODE(halt), .WAIT_MODE(wt),
        .CMP_HI(cmp), .PIN_LEVEL_I(pin_i), .PIN_LEVEL_O(pin_o), .CHAN_SEL(chan),
        .CONV_EN(conv_en), .SAMPLE(sample), .TRIAL_CODE(trial));
    sac_analog_model afe (.clk(clk), .chan_sel(chan), .conv_en(conv_en),
        .trial_code(trial), .cmp_hi(cmp));
    initial begin
        forever #5 clk = ~clk;
    end
    function automatic logic [15:0] fn_lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic close_out();
        $display("checks=%0d failures=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watcher: pops a note per acknowledge, pin echo, widest step spacing
    always @(posedge clk) begin
        cycles++;
        lfsr = fn_lfsr(lfsr);
        if (ack === 1'b1) begin
            cur = notes.pop_front();
            if (cur.chk) `CHK(rdat, {24'h000000, cur.val})
        end
        if (arst_n && cycles > 22) `CHK(pin_o, pin_q)
        pin_q = pin_i;
        pin_i <= lfsr;
        if (sample) begin
            gcnt = 0;
            armed = 1'b0;
        end else if (trial !== trial_q) begin
            if (armed && gcnt > gap) gap = gcnt;
            armed = 1'b1;
            gcnt = 1;
        end else begin
            gcnt++;
        end
        trial_q = trial;
        // Whole run needs about a thousand cycles; this only cuts a hang
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
    // One classic cycle; request held until ack is seen, then dropped a cycle
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
        input logic chk, output logic [7:0] rd);
        int n;
        n = 0;
        notes.push_back('{chk, d});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n == 20) begin
            fail_count++;
            close_out();
        end
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] rd;
        bus(1'b1, idx, d, 1'b0, rd);
    endtask
    task automatic rdx(input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] rd;
        bus(1'b0, idx, e, 1'b1, rd);
    endtask
    task automatic poll();
        logic [7:0] rd;
        int n;
        rd = 8'h00;
        n = 0;
        while (rd[7] !== 1'b1 && n < 300) begin
            bus(1'b0, 8'h45, 8'h00, 1'b0, rd);
            n++;
        end
        `CHK(rd[7], 1'b1)
    endtask
    initial begin
        logic [3:0] c;
        logic [9:0] e;
        int lv;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // Reset values, refused writes and an unmapped index
        rdx(8'h45, 8'h00);
        rdx(8'h46, 8'h00);
        rdx(8'h47, 8'h00);
        wr(8'h45, 8'h80);
        wr(8'h46, 8'hAA);
        wr(8'h50, 8'hFF);
        rdx(8'h50, 8'h00);
        rdx(8'h45, 8'h00);
        rdx(8'h46, 8'h00);
        // Every channel, cycling the four clock choices; ends saturate
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            lv = (i == 0) ? 2000 : (i == 15) ? -5 : int'(lfsr[9:0]);
            e = (lv > 1023) ? 10'h3FF : (lv < 0) ? 10'h000 : 10'(lv);
            afe.level[c] = lv;
            wr(8'h45, {1'b0, c[0], 1'b1, c[1], c});
            `CHK(chan, c)
            `CHK(conv_en, 1'b1)
            gap = 0;
            poll();
            `CHK(gap, (c[1:0] == 2'b01) ? 1 : (c[1:0] == 2'b10) ? 4 : 2)
            rdx(8'h47, {6'h00, e[1:0]});
            // Halt freezes completions so the flag read below is deterministic
            halt <= 1'b1;
            rdx(8'h46, e[9:2]);
            rdx(8'h45, {1'b0, c[0], 1'b1, c[1], c});
            halt <= 1'b0;
        end
        // Low read freezes both bytes until the high read
        afe.level[5] = 100;
        wr(8'h45, 8'h65);
        poll();
        rdx(8'h47, 8'h00);
        afe.level[5] = 900;
        repeat (60) @(posedge clk);
        // No completion may race the unlocking read
        halt <= 1'b1;
        rdx(8'h46, 8'h19);
        halt <= 1'b0;
        poll();
        rdx(8'h46, 8'hE1);
        // Switching off also unlocks and stops the converter
        poll();
        rdx(8'h47, 8'h00);
        afe.level[5] = 3;
        wr(8'h45, 8'h45);
        `CHK(conv_en, 1'b0)
        wr(8'h45, 8'h65);
        poll();
        rdx(8'h46, 8'h00);
        // Channel change mid-conversion restarts on the new input
        afe.level[6] = 100;
        afe.level[7] = 600;
        wr(8'h45, 8'h76);
        repeat (8) @(posedge clk);
        wr(8'h45, 8'h77);
        rdx(8'h45, 8'h77);
        poll();
        rdx(8'h47, 8'h00);
        rdx(8'h46, 8'h96);
        // Wait mode ignored, halt powers down, work resumes after it
        wt <= 1'b1;
        @(posedge clk);
        `CHK(conv_en, 1'b1)
        halt <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        `CHK(conv_en, 1'b0)
        halt <= 1'b0;
        wt <= 1'b0;
        wr(8'h45, 8'h77);
        poll();
        rdx(8'h46, 8'h96);
        close_out();
    end
endmodule
